// ### stc_timer.sv
// sixteen bit timer counter with axi4-lite register access
`timescale 1ns/100ps
`default_nettype none
module stc_timer (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [stc_pkg::STC_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [stc_pkg::STC_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic osc_in_pin_i,
  input wire logic osc_out_pin_i,
  input wire logic [1:0] port_c_direction_i,
  input wire logic [1:0] port_c_out_i,
  input wire logic sleep_i,
  output logic [1:0] pin_out_o,
  output logic [1:0] pin_oe_o,
  output logic [1:0] port_read_o,
  output logic osc_run_o,
  output logic osc_low_power_o,
  output logic irq_o,
  output logic adc_start_o
);
  import stc_pkg::*;
  stc_core_if cif ();
  logic [7:0] ctrl;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [7:0] hbuf;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [15:0] cmp_val;
  logic [4:0] cmp_cfg;
  logic osc_sleep_power_option;
  logic [STC_ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane;
  logic aw_held;
  logic w_held;
  logic wr_do;
  logic wr_ok;
  logic wr_lo;
  logic wr_hi;
  logic wr_cnt;
  logic rd_do;
  logic rd_ok;
  logic [7:0] rd_byte;
  logic ovf_set;
  logic flag_clr;
  logic wide;
  logic ext_src;

  assign wide = ctrl[STC_B_WIDE];
  assign cif.on = ctrl[STC_B_ON];
  assign cif.src_sel = ctrl[STC_B_SRC];
  assign cif.sync_dis = ctrl[STC_B_SYNC_DIS];
  assign cif.presc = ctrl[STC_B_PS_LO+1:STC_B_PS_LO];
  assign cif.count = count;
  assign cif.cmp_val = cmp_val;
  assign cif.cmp_mode = cmp_cfg[3:0];
  // crystal input when the oscillator runs, else the clock pin
  assign ext_src = ctrl[STC_B_OSC_EN] ? osc_in_pin_i : osc_out_pin_i;

  stc_tick_gen u_tick (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .ext_i(ext_src),
    .cif(cif.tick_mp)
  );

  stc_cmp_trig u_cmp (
    .cif(cif.cmp_mp)
  );

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channels
  assign wr_do = aw_held & w_held & ~s_axi_bvalid_o;
  assign wr_ok = wr_do & w_lane;
  assign wr_lo = wr_ok & (aw_addr == STC_OFS_CNT_LO);
  assign wr_hi = wr_ok & (aw_addr == STC_OFS_CNT_HI);
  assign wr_cnt = wr_lo | (wr_hi & ~wide);
  assign cif.presc_clr = wr_lo;

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_awready_o <= 1'b0;
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      s_axi_awready_o <= 1'b0;
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr_i[STC_ADDR_W-1:2], 2'b00};
    end
    else if (wr_do)
      aw_held <= 1'b0;
    else if (!aw_held)
      s_axi_awready_o <= 1'b1;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_wready_o <= 1'b0;
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end
    else if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      s_axi_wready_o <= 1'b0;
      w_held <= 1'b1;
      w_byte <= s_axi_wdata_i[7:0];
      w_lane <= s_axi_wstrb_i[0];
    end
    else if (wr_do)
      w_held <= 1'b0;
    else if (!w_held)
      s_axi_wready_o <= 1'b1;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= STC_RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= (aw_addr > STC_OFS_CONFIG) ? STC_RESP_SLVERR : STC_RESP_OKAY;
    end
    else if (s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      ctrl <= STC_RST_CTRL;
    else if (wr_ok && aw_addr == STC_OFS_CTRL)
      ctrl <= w_byte;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cmp_val <= STC_RST_CMP;
      cmp_cfg <= STC_RST_CMP_CFG;
      overflow_irq_enable <= 1'b0;
      osc_sleep_power_option <= STC_RST_OSC_OPT;
    end
    else if (wr_ok)
    begin
      if (aw_addr == STC_OFS_CMP_LO)
        cmp_val[7:0] <= w_byte;
      if (aw_addr == STC_OFS_CMP_HI)
        cmp_val[15:8] <= w_byte;
      if (aw_addr == STC_OFS_CMP_CFG)
        cmp_cfg <= w_byte[4:0];
      if (aw_addr == STC_OFS_IRQ_EN)
        overflow_irq_enable <= w_byte[0];
      if (aw_addr == STC_OFS_CONFIG)
        osc_sleep_power_option <= w_byte[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // count register
  always_comb
  begin
    next_count = count;
    if (wr_lo)
      next_count = {wide ? hbuf : count[15:8], w_byte};
    else if (wr_hi && !wide)
      next_count = {w_byte, count[7:0] + 8'(cif.tick)};
    else if (cif.trig)
      next_count = STC_RST_CNT;
    else if (cif.tick)
      next_count = count + 16'h0001;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      count <= STC_RST_CNT;
    else
      count <= next_count;
  end

  // high byte buffer
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      hbuf <= 8'h00;
    else if (wr_hi && wide)
      hbuf <= w_byte;
    else if (rd_do && wide && s_axi_araddr_i[STC_ADDR_W-1:2] == STC_OFS_CNT_LO[STC_ADDR_W-1:2])
      hbuf <= count[15:8];
  end

  //////////////////////////////////////////////////////////////////////////////
  // overflow flag, set beats clear
  assign ovf_set = cif.tick & ~wr_cnt & ~cif.trig & (count == STC_CNT_MAX);
  assign flag_clr = wr_ok & (aw_addr == STC_OFS_FLAG) & w_byte[0];

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      overflow_flag <= 1'b0;
    else
      overflow_flag <= ovf_set | (overflow_flag & ~flag_clr);
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= overflow_flag & overflow_irq_enable;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      adc_start_o <= 1'b0;
    else
      adc_start_o <= cif.trig & cmp_cfg[STC_B_ADC_EN];
  end

  //////////////////////////////////////////////////////////////////////////////
  // oscillator and pin control
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      osc_run_o <= 1'b0;
      osc_low_power_o <= 1'b0;
      pin_out_o <= 2'h0;
      pin_oe_o <= 2'h0;
      port_read_o <= 2'h0;
    end
    else
    begin
      osc_run_o <= ctrl[STC_B_OSC_EN];
      osc_low_power_o <= ~osc_sleep_power_option & sleep_i;
      pin_out_o <= port_c_out_i;
      if (ctrl[STC_B_OSC_EN])
      begin
        pin_oe_o <= 2'h0;
        port_read_o <= 2'h0;
      end
      else
      begin
        pin_oe_o <= ~port_c_direction_i;
        port_read_o <= {osc_in_pin_i, osc_out_pin_i};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channels
  assign rd_do = s_axi_arvalid_i & s_axi_arready_o;

  always_comb
  begin
    rd_ok = 1'b1;
    case ({s_axi_araddr_i[STC_ADDR_W-1:2], 2'b00})
      STC_OFS_CTRL: rd_byte = ctrl;
      STC_OFS_CNT_LO: rd_byte = count[7:0];
      STC_OFS_CNT_HI: rd_byte = wide ? hbuf : count[15:8];
      STC_OFS_FLAG: rd_byte = {7'h00, overflow_flag};
      STC_OFS_IRQ_EN: rd_byte = {7'h00, overflow_irq_enable};
      STC_OFS_CMP_LO: rd_byte = cmp_val[7:0];
      STC_OFS_CMP_HI: rd_byte = cmp_val[15:8];
      STC_OFS_CMP_CFG: rd_byte = {3'h0, cmp_cfg};
      STC_OFS_CONFIG: rd_byte = {7'h00, osc_sleep_power_option};
      default:
      begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= STC_RESP_OKAY;
    end
    else if (rd_do)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h00_0000, rd_byte};
      s_axi_rresp_o <= rd_ok ? STC_RESP_OKAY : STC_RESP_SLVERR;
    end
    else if (s_axi_rvalid_o)
    begin
      if (s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
    end
    else
      s_axi_arready_o <= 1'b1;
  end
endmodule
`default_nettype wire

// ### stc_pkg.sv
// constants for the sixteen bit timer counter
package stc_pkg;
  localparam int unsigned STC_ADDR_W = 6;
  // register byte offsets
  localparam logic [5:0] STC_OFS_CTRL = 6'h00;
  localparam logic [5:0] STC_OFS_CNT_LO = 6'h04;
  localparam logic [5:0] STC_OFS_CNT_HI = 6'h08;
  localparam logic [5:0] STC_OFS_FLAG = 6'h0c;
  localparam logic [5:0] STC_OFS_IRQ_EN = 6'h10;
  localparam logic [5:0] STC_OFS_CMP_LO = 6'h14;
  localparam logic [5:0] STC_OFS_CMP_HI = 6'h18;
  localparam logic [5:0] STC_OFS_CMP_CFG = 6'h1c;
  localparam logic [5:0] STC_OFS_CONFIG = 6'h20;
  // control register bit positions
  localparam int unsigned STC_B_ON = 0;
  localparam int unsigned STC_B_SRC = 1;
  localparam int unsigned STC_B_SYNC_DIS = 2;
  localparam int unsigned STC_B_OSC_EN = 3;
  localparam int unsigned STC_B_PS_LO = 4;
  localparam int unsigned STC_B_WIDE = 7;
  // compare config bit positions
  localparam int unsigned STC_B_ADC_EN = 4;
  // reset values, count limit, special mode code and response codes
  localparam logic [7:0] STC_RST_CTRL = 8'h00;
  localparam logic [15:0] STC_RST_CNT = 16'h0000;
  localparam logic [15:0] STC_RST_CMP = 16'hffff;
  localparam logic [4:0] STC_RST_CMP_CFG = 5'h00;
  localparam logic STC_RST_OSC_OPT = 1'b1;
  localparam logic [15:0] STC_CNT_MAX = 16'hffff;
  localparam logic [3:0] STC_MODE_SPECIAL = 4'hb;
  localparam logic [1:0] STC_RESP_OKAY = 2'h0;
  localparam logic [1:0] STC_RESP_SLVERR = 2'h2;
endpackage

// ### stc_core_if.sv
// signals shared between the counter core, tick generator and compare unit
`timescale 1ns/100ps
`default_nettype none
interface stc_core_if;
  logic on;
  logic src_sel;
  logic sync_dis;
  logic [1:0] presc;
  logic presc_clr;
  logic tick;
  logic trig;
  logic [15:0] count;
  logic [15:0] cmp_val;
  logic [3:0] cmp_mode;
  modport top_mp (output on, src_sel, sync_dis, presc, presc_clr, count, cmp_val, cmp_mode, input tick, trig);
  modport tick_mp (input on, src_sel, sync_dis, presc, presc_clr, output tick);
  modport cmp_mp (input on, src_sel, sync_dis, tick, count, cmp_val, cmp_mode, output trig);
endinterface
`default_nettype wire

// ### stc_tick_gen.sv
// input selection, synchroniser and prescaler for the counter
`timescale 1ns/100ps
`default_nettype none
module stc_tick_gen (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ext_i,
  stc_core_if.tick_mp cif
);
  import stc_pkg::*;
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic async_q;
  logic [2:0] pcnt;
  logic [2:0] mask;
  logic ev;
  //////////////////////////////////////////////////////////////////////////////
  // two flop synchroniser plus edge history
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end
    else
    begin
      sync_a <= ext_i;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end
  // unsynchronised edge history
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      async_q <= 1'b0;
    else
      async_q <= ext_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  // source event selection
  always_comb
  begin
    if (!cif.src_sel)
      ev = cif.on;
    else if (cif.sync_dis)
      ev = cif.on & ext_i & ~async_q;
    else
      ev = cif.on & sync_b & ~sync_c;
  end
  always_comb
  begin
    case (cif.presc)
      2'd0: mask = 3'h0;
      2'd1: mask = 3'h1;
      2'd2: mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end
  // prescale counter
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      pcnt <= 3'h0;
    else if (cif.presc_clr)
      pcnt <= 3'h0;
    else if (ev)
      pcnt <= pcnt + 3'h1;
  end
  assign cif.tick = ev & ((pcnt & mask) == mask);
endmodule
`default_nettype wire

// ### stc_cmp_trig.sv
// special event trigger of the compare unit
`timescale 1ns/100ps
`default_nettype none
module stc_cmp_trig (
  stc_core_if.cmp_mp cif
);
  import stc_pkg::*;
  logic sel;
  logic sync_ok;
  assign sel = (cif.cmp_mode == STC_MODE_SPECIAL);
  assign sync_ok = !(cif.src_sel && cif.sync_dis);
  // match on the advancing edge so count runs 0 up to cmp_val
  assign cif.trig = sel & sync_ok & cif.on & cif.tick & (cif.count == cif.cmp_val);
endmodule
`default_nettype wire

// ### stc_timer_chk.sv
// port assertions for the timer counter
`timescale 1ns/100ps
`default_nettype none
module stc_timer_chk (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [stc_pkg::STC_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic [1:0] port_c_direction_i,
  input wire logic sleep_i,
  input wire logic [1:0] pin_oe_o,
  input wire logic [1:0] port_read_o,
  input wire logic osc_run_o,
  input wire logic osc_low_power_o
);
  import stc_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////
  a_osc_pins_in: assert property (osc_run_o && $past(osc_run_o) && !$past(sys_rst_i) |-> pin_oe_o == 2'h0 && port_read_o == 2'h0)
    else $error("pins not inputs with oscillator on");
  a_pins_follow_dir: assert property (!osc_run_o && !$past(osc_run_o) && !$past(sys_rst_i) |-> pin_oe_o == ~$past(port_c_direction_i))
    else $error("pin enable not from direction");
  a_low_power_sleep: assert property (osc_low_power_o |-> $past(sleep_i))
    else $error("low power outside sleep");
  a_osc_keeps_run: assert property (sleep_i && $past(sleep_i) && $past(osc_run_o) |-> osc_run_o)
    else $error("oscillator stopped in sleep");
  a_rd_latency: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_rd_unmapped: assert property (s_axi_arvalid_i && s_axi_arready_o
    && s_axi_araddr_i[STC_ADDR_W-1:2] > STC_OFS_CONFIG[STC_ADDR_W-1:2]
    |=> s_axi_rresp_o == STC_RESP_SLVERR && s_axi_rdata_o == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_rd_ack_drop: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read valid held after ack");
  a_ar_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("second read accepted");
  a_wr_ready_drop: assert property ($rose(s_axi_bvalid_o) |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write ready during response");
endmodule
`default_nettype wire

// ### stc_osc_model.sv
// crystal and external clock sources at the counter pins
`timescale 1ns/100ps
`default_nettype none
module stc_osc_model #(
  parameter int XTAL_HALF = 3,
  parameter int EXT_HALF = 2
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  output logic osc_in_pin_o,
  output logic osc_out_pin_o
);
  int xt_cnt;
  int ex_cnt;
  ////////////////////////////////////////////////////////////
  // both sources run free
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      xt_cnt <= 0;
      ex_cnt <= 0;
      osc_in_pin_o <= 1'b0;
      osc_out_pin_o <= 1'b0;
    end
    else
    begin
      xt_cnt <= (xt_cnt == XTAL_HALF - 1) ? 0 : xt_cnt + 1;
      ex_cnt <= (ex_cnt == EXT_HALF - 1) ? 0 : ex_cnt + 1;
      if (xt_cnt == XTAL_HALF - 1)
        osc_in_pin_o <= ~osc_in_pin_o;
      if (ex_cnt == EXT_HALF - 1)
        osc_out_pin_o <= ~osc_out_pin_o;
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the timer counter
`timescale 1ns/100ps
`default_nettype none
`define CMP(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  import stc_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [STC_ADDR_W-1:0] s_axi_awaddr_i = 6'h00;
  logic [STC_ADDR_W-1:0] s_axi_araddr_i = 6'h00;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000;
  logic [3:0] s_axi_wstrb_i = 4'h0;
  logic s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b1;
  logic s_axi_rready_i = 1'b1;
  logic [1:0] port_c_direction_i = 2'h0;
  logic [1:0] port_c_out_i = 2'h0;
  logic sleep_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, pin_out_o, pin_oe_o, port_read_o;
  logic [31:0] s_axi_rdata_o, r0, r1;
  logic osc_run_o, osc_low_power_o, irq_o, adc_start_o, osc_in_pin_i, osc_out_pin_i;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int adc_cnt = 0;
  logic [67:0] exp_q [$];
  logic [67:0] ent;
  logic [7:0] v;
  logic [1:0] pins_q = 2'h0;
  logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h01};
  logic [7:0] cfg_tab [10] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h00, 8'h03, 8'h07, 8'h13, 8'h0b, 8'h0f};
  int dif_tab [10] = '{48, 24, 12, 6, 0, 12, 12, 6, 8, 8};
  always #10 core_clk_i = ~core_clk_i;
  stc_timer stc_timer_inst (.core_clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .osc_in_pin_i, .osc_out_pin_i, .port_c_direction_i, .port_c_out_i,
    .sleep_i, .pin_out_o, .pin_oe_o, .port_read_o, .osc_run_o, .osc_low_power_o, .irq_o, .adc_start_o);
  stc_osc_model stc_osc_model_inst (.core_clk_i, .sys_rst_i, .osc_in_pin_o(osc_in_pin_i), .osc_out_pin_o(osc_out_pin_i));
  ////////////////////////////////////////////////////////////
  task automatic wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task automatic chk(input logic [33:0] g);
    begin
      if (exp_q.size() == 0)
      begin
        miscompares++;
        $display("ERROR t=%0t got %h exp %h", $time, g, 34'h0_0000_0000);
      end
      else
      begin
        ent = exp_q.pop_front();
        `CMP(g & ent[67:34], ent[33:0] & ent[67:34])
      end
    end
  endtask
  // result watcher and timeout
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    pins_q <= {osc_in_pin_i, osc_out_pin_i};
    if (adc_start_o)
      adc_cnt <= adc_cnt + 1;
    if (s_axi_rvalid_o && s_axi_rready_i)
      chk({s_axi_rresp_o, s_axi_rdata_o});
    if (s_axi_bvalid_o && s_axi_bready_i)
      chk({s_axi_bresp_o, 32'h0000_0000});
    if (cyc == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [STC_ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] rs = 2'h0);
    begin
      exp_q.push_back({34'h3_ffff_ffff, rs, 32'h0000_0000});
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= {24'h00_0000, d};
      s_axi_wstrb_i <= 4'h1;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      do
      begin
        @(posedge core_clk_i);
        if (s_axi_awready_o && s_axi_awvalid_i)
          s_axi_awvalid_i <= 1'b0;
        if (s_axi_wready_o && s_axi_wvalid_i)
          s_axi_wvalid_i <= 1'b0;
      end while (s_axi_bvalid_o !== 1'b1);
    end
  endtask
  task automatic rd(input logic [STC_ADDR_W-1:0] a, input logic [7:0] e, input logic on = 1'b1, input logic [1:0] rs = 2'h0);
    begin
      exp_q.push_back({{34{on}}, rs, 24'h00_0000, e});
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      do
      begin
        @(posedge core_clk_i);
        if (s_axi_arready_o && s_axi_arvalid_i)
          s_axi_arvalid_i <= 1'b0;
      end while (s_axi_rvalid_o !== 1'b1);
      v = s_axi_rdata_o[7:0];
    end
  endtask
  // two low byte reads l cycles apart
  task automatic span(input int l, input int d);
    logic [7:0] v0;
    begin
      rd(STC_OFS_CNT_LO, 8'h00, 1'b0);
      v0 = v;
      repeat (l - 2) @(posedge core_clk_i);
      rd(STC_OFS_CNT_LO, v0 + 8'(d));
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h8dbd_250e));
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    for (int i = 0; i < 9; i++)
      rd(6'(4 * i), rst_tab[i]);
    rd(6'h24, 8'h00, 1'b1, STC_RESP_SLVERR);
    wr(6'h24, 8'h55, STC_RESP_SLVERR);
    $display("test registers done");
    for (int i = 0; i < 10; i++)
    begin
      port_c_direction_i <= 2'($urandom);
      port_c_out_i <= 2'($urandom);
      wr(STC_OFS_CTRL, cfg_tab[i]);
      repeat (20) @(posedge core_clk_i);
      span(48, dif_tab[i]);
    end
    $display("test counting done");
    wr(STC_OFS_CTRL, 8'h00);
    wr(STC_OFS_CNT_HI, 8'hff);
    wr(STC_OFS_CNT_LO, 8'hf0);
    wr(STC_OFS_CTRL, 8'h01);
    repeat (40) @(posedge core_clk_i);
    rd(STC_OFS_FLAG, 8'h01);
    `CMP(irq_o, 1'b0)
    rd(STC_OFS_CNT_HI, 8'h00);
    rd(STC_OFS_CNT_LO, 8'h00, 1'b0);
    r0 = {24'h00_0000, v + 8'h30};
    wr(STC_OFS_CNT_HI, 8'h80);
    repeat (43) @(posedge core_clk_i);
    rd(STC_OFS_CNT_LO, r0[7:0]);
    rd(STC_OFS_CNT_HI, 8'h80);
    wr(STC_OFS_IRQ_EN, 8'h01);
    repeat (3) @(posedge core_clk_i);
    `CMP(irq_o, 1'b1)
    wr(STC_OFS_FLAG, 8'h01);
    repeat (3) @(posedge core_clk_i);
    `CMP(irq_o, 1'b0)
    $display("test overflow done");
    wr(STC_OFS_CTRL, 8'h00);
    wr(STC_OFS_CMP_LO, 8'h10);
    wr(STC_OFS_CMP_HI, 8'h00);
    wr(STC_OFS_CMP_CFG, 8'h1b);
    wr(STC_OFS_CNT_HI, 8'h00);
    wr(STC_OFS_CNT_LO, 8'h00);
    wr(STC_OFS_CTRL, 8'h01);
    repeat (10) @(posedge core_clk_i);
    span(34, 0);
    r0 = 32'(adc_cnt);
    repeat (34) @(posedge core_clk_i);
    `CMP(32'(adc_cnt) - r0, 32'h0000_0002)
    wr(STC_OFS_CTRL, 8'h00);
    wr(STC_OFS_CMP_LO, 8'hff);
    wr(STC_OFS_CMP_HI, 8'hff);
    wr(STC_OFS_CNT_HI, 8'hff);
    wr(STC_OFS_CNT_LO, 8'hf0);
    wr(STC_OFS_CTRL, 8'h01);
    repeat (40) @(posedge core_clk_i);
    rd(STC_OFS_FLAG, 8'h00);
    rd(STC_OFS_CNT_HI, 8'h00);
    wr(STC_OFS_CMP_CFG, 8'h00);
    $display("test trigger done");
    r0 = $urandom;
    r1 = $urandom;
    wr(STC_OFS_CTRL, 8'h00);
    wr(STC_OFS_CNT_HI, r0[7:0]);
    wr(STC_OFS_CNT_LO, r0[15:8]);
    rd(STC_OFS_CNT_HI, r0[7:0]);
    wr(STC_OFS_CTRL, 8'h80);
    wr(STC_OFS_CNT_HI, r0[23:16]);
    rd(STC_OFS_CNT_HI, r0[23:16]);
    rd(STC_OFS_CNT_LO, r0[15:8]);
    rd(STC_OFS_CNT_HI, r0[7:0]);
    wr(STC_OFS_CNT_HI, r1[7:0]);
    wr(STC_OFS_CNT_LO, r1[15:8]);
    wr(STC_OFS_CTRL, 8'h00);
    rd(STC_OFS_CNT_HI, r1[7:0]);
    rd(STC_OFS_CNT_LO, r1[15:8]);
    $display("test wide access done");
    wr(STC_OFS_CTRL, 8'h08);
    wr(STC_OFS_CONFIG, 8'h00);
    sleep_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    `CMP(osc_low_power_o, 1'b1)
    `CMP(osc_run_o, 1'b1)
    `CMP(port_read_o, 2'h0)
    `CMP(pin_oe_o, 2'h0)
    sleep_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    `CMP(osc_low_power_o, 1'b0)
    wr(STC_OFS_CTRL, 8'h00);
    port_c_direction_i <= 2'($urandom);
    port_c_out_i <= 2'($urandom);
    repeat (3) @(posedge core_clk_i);
    `CMP(pin_oe_o, ~port_c_direction_i)
    `CMP(pin_out_o, port_c_out_i)
    `CMP(port_read_o, pins_q)
    $display("test sleep done");
    wrap_up();
  end
endmodule
bind stc_timer stc_timer_chk stc_timer_chk_inst (.core_clk_i, .sys_rst_i, .s_axi_araddr_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_awready_o,
  .s_axi_wready_o, .s_axi_bvalid_o, .port_c_direction_i, .sleep_i, .pin_oe_o, .port_read_o, .osc_run_o,
  .osc_low_power_o);
`default_nettype wire
